// [logic/dcr_pkg.sv]
/*
  Constants for the device configuration and auxiliary pin register bank.
  Assumes a 32-bit AHB-Lite register bus; registers are 16 bits in the low half.
*/
package dcr_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CFG2     = 8'h15;
  localparam logic [7:0]  IDX_AUX      = 8'h16;
  localparam logic [9:0]  ADDR_CFG2    = {IDX_CFG2, 2'h0};
  localparam logic [9:0]  ADDR_AUX     = {IDX_AUX, 2'h0};
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

  // Second device configuration register
  localparam int          COEF_MSB     = 15;
  localparam int          COEF_LSB     = 13;
  localparam logic [2:0]  COEF_BYPASS  = 3'h7;
  localparam int          PUMP_BIT     = 6;
  localparam int          FRST_BIT     = 5;
  localparam int          ADC_TEST_BIT = 4;
  localparam int          ECHO_BIT     = 2;
  localparam int          ACQ_WD_BIT   = 1;
  localparam int          BAL_WD_BIT   = 0;
  localparam logic [15:0] CFG2_RESET   = 16'h4000;
  localparam logic [15:0] CFG2_MASK    = 16'hE077;

  // Auxiliary pin function register
  localparam int          TWS_BIT      = 15;
  localparam int          MODE_LSB     = 8;
  localparam int          DIR_LSB      = 0;
  localparam int          NUM_PINS     = 6;
  localparam logic [15:0] AUX_RESET    = 16'h3F00;
  localparam logic [15:0] AUX_MASK     = 16'hBF3F;
endpackage : dcr_pkg

// [logic/dcr_ahb_slave.sv]
/*
  AHB-Lite slave front end: zero wait states, OKAY only, registered read data.
  Assumes the register file supplies read data for the index being addressed,
  already reflecting a write that completes on the same edge.
*/
`timescale 1ns/1ns
module dcr_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  input  wire logic [15:0] rd_data,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  rd_idx,
  output logic             wr_en,
  output logic      [7:0]  wr_idx,
  output logic      [15:0] wr_data
);
  logic        wpend_reg;
  logic        wpend_next;
  logic [7:0]  widx_reg;
  logic [7:0]  widx_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        take;

  always_comb begin
    take        = hsel && hready && htrans[1];
    rd_idx      = haddr[9:2];
    wpend_next  = take && hwrite && (hsize == dcr_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
    widx_next   = take ? haddr[9:2] : widx_reg;
    // Unmapped indices read zero because the bank returns zero for them
    hrdata_next = (take && !hwrite) ? {16'h0000, rd_data} : hrdata_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_reg  <= 1'b0;
      widx_reg   <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wpend_reg  <= wpend_next;
      widx_reg   <= widx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign wr_en     = wpend_reg;
  assign wr_idx    = widx_reg;
  assign wr_data   = hwdata[15:0];
  assign hrdata    = hrdata_reg;
  // Never stalls, never errors; held in reset-safe constants
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : dcr_ahb_slave

// [logic/dcr_pin_mux.sv]
/*
  Per-pin function decode for the six auxiliary multifunction pins.
  Assumes an outside two-wire controller supplies pull-low requests.
*/
`timescale 1ns/1ns
module dcr_pin_mux (
  input  wire logic [5:0] digital_mode,
  input  wire logic [5:0] direction,
  input  wire logic       two_wire_sel,
  input  wire logic [5:0] gpio_drive,
  input  wire logic       sda_pull_low,
  input  wire logic       scl_pull_low,
  output logic      [5:0] pin_o,
  output logic      [5:0] pin_oe,
  output logic      [5:0] analog_sel,
  output logic      [5:0] pulldown_en
);
  genvar n;
  generate
    for (n = 0; n < dcr_pkg::NUM_PINS; n++) begin : g_pin
      logic tw;
      logic od_low;
      assign tw = two_wire_sel && (n < 2);
      assign od_low = (n == 0) ? sda_pull_low : scl_pull_low;
      // Open-drain: only ever drives low in two-wire mode
      assign pin_o[n]       = tw ? 1'b0 : gpio_drive[n]; // RULE16
      assign pin_oe[n]      = tw ? od_low : (digital_mode[n] && direction[n]); // RULE18
      assign analog_sel[n]  = !tw && !digital_mode[n]; // RULE17
      assign pulldown_en[n] = !tw && digital_mode[n] && !direction[n]; // RULE19
    end
  endgenerate
endmodule : dcr_pin_mux

// [logic/dcr_regs.sv]
/*
  Device configuration register and auxiliary pin function register with
  their pin-level effects: filter coefficient, charge pump disable, forced
  hard reset pull-down, alert pin DC test, watchdog disables, pin modes.
  Assumes AHB-Lite access, one clock, and outside alert, watchdog, filter,
  GPIO output and two-wire controller logic.
*/
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Function
// RULE1: three-bit filter coefficient, resets to 010
// RULE2: coefficient weights newest sample; 111 bypasses
// RULE3: bit 6 disables high-voltage charge pump
// RULE4: bit 5 pulls shutdown pin low
// RULE5: clearing bit 5 releases the pull-down
// RULE6: host should pause link during forced reset
// RULE7: bit 4 puts alert pin in DC test
// RULE8: DC test drives alert low when alert present
// RULE9: user alert writes force alert pin level
// RULE10: DC test works in every link configuration
// RULE11: reserved bit 2 reads back written value
// RULE12: bit 1 disables acquisition watchdog, keeps flag
// RULE13: bit 0 disables balance watchdog, keeps flag
// RULE14: bit 15 selects two-wire controller, resets 0
// RULE15: mode bits reset ones, direction bits zero
// RULE16: two-wire mode uses pins 0 and 1
// RULE17: mode bit 0 analog, 1 digital
// RULE18: direction bit 1 output, digital only
// RULE19: two-wire ignores pin 1:0 bits, reads back
// RULE20: unused bits read zero, writes ignored
module dcr_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        alert_present,
  input  wire logic        normal_alert_o,
  input  wire logic        normal_alert_oe,
  input  wire logic        user_alert_write,
  input  wire logic        user_alert_level,
  input  wire logic [5:0]  aux_pin_i,
  input  wire logic [5:0]  gpio_drive,
  input  wire logic        sda_pull_low,
  input  wire logic        scl_pull_low,
  output logic      [2:0]  filter_coefficient,
  output logic             filter_bypass,
  output logic             hv_pump_disable,
  output logic             shutdown_pin_o,
  output logic             shutdown_pin_oe,
  output logic             alert_output_pin_o,
  output logic             alert_output_pin_oe,
  output logic             acquisition_watchdog_disable,
  output logic             balance_watchdog_disable,
  output logic      [5:0]  aux_pin_o,
  output logic      [5:0]  aux_pin_oe,
  output logic      [5:0]  aux_analog_sel,
  output logic      [5:0]  aux_pulldown_en,
  output logic             sda_in
);
  logic [7:0]  rd_idx;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  logic [15:0] cfg2_reg;
  logic [15:0] cfg2_next;
  logic [15:0] aux_reg;
  logic [15:0] aux_next;
  logic        ovr_valid_reg;
  logic        ovr_valid_next;
  logic        ovr_level_reg;
  logic        ovr_level_next;

  logic [2:0]  coef_reg;
  logic        bypass_reg;
  logic        pump_reg;
  logic        shdn_oe_reg;
  logic        alrt_o_reg;
  logic        alrt_o_next;
  logic        alrt_oe_reg;
  logic        alrt_oe_next;
  logic        acq_wd_reg;
  logic        bal_wd_reg;
  logic [5:0]  pin_o_reg;
  logic [5:0]  pin_oe_reg;
  logic [5:0]  ana_reg;
  logic [5:0]  pd_reg;
  logic        sda_reg;

  logic [5:0]  mux_o;
  logic [5:0]  mux_oe;
  logic [5:0]  mux_ana;
  logic [5:0]  mux_pd;
  logic        test_en;

  dcr_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .rd_data   (rd_data),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_idx    (rd_idx),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data)
  );

  // Register file
  always_comb begin
    cfg2_next = cfg2_reg;
    aux_next  = aux_reg;
    if (wr_en && wr_idx == dcr_pkg::IDX_CFG2) begin
      cfg2_next = wr_data & dcr_pkg::CFG2_MASK; // RULE20
    end
    if (wr_en && wr_idx == dcr_pkg::IDX_AUX) begin
      aux_next = wr_data & dcr_pkg::AUX_MASK; // RULE20
    end
    // Read from next values so a read right after a write sees the new data
    case (rd_idx)
      dcr_pkg::IDX_CFG2: rd_data = cfg2_next; // RULE11
      dcr_pkg::IDX_AUX:  rd_data = aux_next; // RULE19
      default:           rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg2_reg <= dcr_pkg::CFG2_RESET; // RULE1
      aux_reg  <= dcr_pkg::AUX_RESET; // RULE15
    end else begin
      cfg2_reg <= cfg2_next;
      aux_reg  <= aux_next;
    end
  end

  // Alert pin DC test override
  assign test_en = cfg2_reg[dcr_pkg::ADC_TEST_BIT];

  always_comb begin
    ovr_valid_next = ovr_valid_reg;
    ovr_level_next = ovr_level_reg;
    if (!test_en) begin
      ovr_valid_next = 1'b0;
    end else if (user_alert_write) begin
      ovr_valid_next = 1'b1; // RULE9
      ovr_level_next = user_alert_level;
    end
    // Link configuration is deliberately not consulted here
    if (test_en) begin
      alrt_oe_next = 1'b1; // RULE10
      alrt_o_next  = ovr_valid_reg ? !ovr_level_reg : !alert_present; // RULE8
    end else begin
      alrt_oe_next = normal_alert_oe; // RULE7
      alrt_o_next  = normal_alert_o;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_valid_reg <= 1'b0;
      ovr_level_reg <= 1'b0;
      alrt_o_reg    <= 1'b1;
      alrt_oe_reg   <= 1'b0;
    end else begin
      ovr_valid_reg <= ovr_valid_next;
      ovr_level_reg <= ovr_level_next;
      alrt_o_reg    <= alrt_o_next;
      alrt_oe_reg   <= alrt_oe_next;
    end
  end

  dcr_pin_mux u_mux (
    .digital_mode (aux_reg[dcr_pkg::MODE_LSB +: 6]),
    .direction    (aux_reg[dcr_pkg::DIR_LSB +: 6]),
    .two_wire_sel (aux_reg[dcr_pkg::TWS_BIT]), // RULE14
    .gpio_drive   (gpio_drive),
    .sda_pull_low (sda_pull_low),
    .scl_pull_low (scl_pull_low),
    .pin_o        (mux_o),
    .pin_oe       (mux_oe),
    .analog_sel   (mux_ana),
    .pulldown_en  (mux_pd)
  );

  // Output stage; every pin-facing signal except the constant shutdown_pin_o leaves from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coef_reg    <= 3'h0;
      bypass_reg  <= 1'b0;
      pump_reg    <= 1'b0;
      shdn_oe_reg <= 1'b0;
      acq_wd_reg  <= 1'b0;
      bal_wd_reg  <= 1'b0;
      pin_o_reg   <= 6'h00;
      pin_oe_reg  <= 6'h00;
      ana_reg     <= 6'h00;
      pd_reg      <= 6'h00;
      sda_reg     <= 1'b1;
    end else begin
      coef_reg    <= cfg2_reg[dcr_pkg::COEF_MSB:dcr_pkg::COEF_LSB]; // RULE1
      bypass_reg  <= cfg2_reg[dcr_pkg::COEF_MSB:dcr_pkg::COEF_LSB] == dcr_pkg::COEF_BYPASS; // RULE2
      pump_reg    <= cfg2_reg[dcr_pkg::PUMP_BIT]; // RULE3
      // Pull-down follows the bit, so clearing it in time releases the pin
      shdn_oe_reg <= cfg2_reg[dcr_pkg::FRST_BIT]; // RULE5
      // Disables only; the timeout flags live elsewhere and are never cleared here
      acq_wd_reg  <= cfg2_reg[dcr_pkg::ACQ_WD_BIT]; // RULE12
      bal_wd_reg  <= cfg2_reg[dcr_pkg::BAL_WD_BIT]; // RULE13
      pin_o_reg   <= mux_o;
      pin_oe_reg  <= mux_oe; // RULE16
      ana_reg     <= mux_ana; // RULE17
      pd_reg      <= mux_pd;
      sda_reg     <= aux_pin_i[0];
    end
  end

  assign filter_coefficient           = coef_reg;
  assign filter_bypass                = bypass_reg;
  assign hv_pump_disable              = pump_reg;
  assign shutdown_pin_o               = 1'b0; // RULE4
  assign shutdown_pin_oe              = shdn_oe_reg;
  assign alert_output_pin_o           = alrt_o_reg;
  assign alert_output_pin_oe          = alrt_oe_reg;
  assign acquisition_watchdog_disable = acq_wd_reg;
  assign balance_watchdog_disable     = bal_wd_reg;
  assign aux_pin_o                    = pin_o_reg;
  assign aux_pin_oe                   = pin_oe_reg;
  assign aux_analog_sel               = ana_reg;
  assign aux_pulldown_en              = pd_reg;
  assign sda_in                       = sda_reg;

  // Checks
  a_coef_write: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
    wr_en && wr_idx == dcr_pkg::IDX_CFG2 |=> ##1
      filter_coefficient == $past(wr_data[dcr_pkg::COEF_MSB:dcr_pkg::COEF_LSB], 2))
    else $error("filter coefficient did not follow write");

  a_bypass_code: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
    filter_bypass ==
      ($past(cfg2_reg[dcr_pkg::COEF_MSB:dcr_pkg::COEF_LSB]) == dcr_pkg::COEF_BYPASS))
    else $error("bypass does not match coefficient 111");

  a_pump_follow: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
    $rose(cfg2_reg[dcr_pkg::PUMP_BIT]) |=> hv_pump_disable)
    else $error("charge pump disable not applied");

  a_shdn_pull: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    cfg2_reg[dcr_pkg::FRST_BIT] |=> shutdown_pin_oe && !shutdown_pin_o)
    else $error("shutdown pin not pulled low");

  a_shdn_release: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
    $fell(cfg2_reg[dcr_pkg::FRST_BIT]) |=> !shutdown_pin_oe)
    else $error("shutdown pull-down not released");

  a_alert_normal: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    !test_en |=> alert_output_pin_oe == $past(normal_alert_oe)
      && alert_output_pin_o == $past(normal_alert_o))
    else $error("alert pin not on normal drive outside DC test");

  a_dc_alert: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
    test_en && !ovr_valid_reg |=> alert_output_pin_oe
      && alert_output_pin_o == !$past(alert_present))
    else $error("alert pin level wrong in DC test");

  a_dc_user: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
    test_en && user_alert_write ##1 test_en |=>
      alert_output_pin_o == !$past(user_alert_level, 2))
    else $error("user alert write did not force pin");

  a_echo_bit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
    wr_en && wr_idx == dcr_pkg::IDX_CFG2 |=>
      cfg2_reg[dcr_pkg::ECHO_BIT] == $past(wr_data[dcr_pkg::ECHO_BIT]))
    else $error("reserved bit does not echo write");

  a_acq_wd_follow: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
    acquisition_watchdog_disable == $past(cfg2_reg[dcr_pkg::ACQ_WD_BIT]))
    else $error("acquisition watchdog disable not applied");

  a_bal_wd_follow: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
    balance_watchdog_disable == $past(cfg2_reg[dcr_pkg::BAL_WD_BIT]))
    else $error("balance watchdog disable not applied");

  a_pin_analog: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
    aux_analog_sel == $past(~aux_reg[dcr_pkg::MODE_LSB +: 6]
      & ~(aux_reg[dcr_pkg::TWS_BIT] ? 6'h03 : 6'h00)))
    else $error("analog select does not follow mode bits");

  a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
    (cfg2_reg & ~dcr_pkg::CFG2_MASK) == 16'h0000 && (aux_reg & ~dcr_pkg::AUX_MASK) == 16'h0000)
    else $error("unused bit set");

  a_sda_drive: assert property (@(posedge hclk) disable iff (!hresetn) // RULE16
    aux_reg[dcr_pkg::TWS_BIT] && sda_pull_low |=> aux_pin_oe[0] && !aux_pin_o[0])
    else $error("data line not pulled low in two-wire mode");
endmodule : dcr_regs

// [sim/dcr_regs_tb.sv]
/*
  Self-checking bench for the configuration and auxiliary pin register bank.
  Assumes dcr_pkg and dcr_regs are compiled first; the bench is the only bus master.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module dcr_regs_tb;
  typedef struct { int src; logic [31:0] val; } dcr_note_s;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        alert_present = 1'h0, normal_alert_o = 1'h1, normal_alert_oe = 1'h0;
  logic        user_alert_write = 1'h0, user_alert_level = 1'h0, look = 1'h0;
  logic [5:0]  aux_pin_i = 6'h0, gpio_drive = 6'h0;
  logic        sda_pull_low = 1'h0, scl_pull_low = 1'h0, rd_dp = 1'h0;
  logic [31:0] hrdata, d, seed_v;
  logic        hreadyout, hresp, filter_bypass, hv_pump_disable, shutdown_pin_o;
  logic        shutdown_pin_oe, alert_output_pin_o, alert_output_pin_oe, sda_in;
  logic        acquisition_watchdog_disable, balance_watchdog_disable;
  logic [2:0]  filter_coefficient;
  logic [5:0]  aux_pin_o, aux_pin_oe, aux_analog_sel, aux_pulldown_en;
  int          err_total = 0;
  int          checks = 0;
  dcr_note_s   q[$];
  dcr_note_s   n;

  dcr_regs dcr_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .alert_present(alert_present), .normal_alert_o(normal_alert_o),
    .normal_alert_oe(normal_alert_oe), .user_alert_write(user_alert_write),
    .user_alert_level(user_alert_level), .aux_pin_i(aux_pin_i), .gpio_drive(gpio_drive),
    .sda_pull_low(sda_pull_low), .scl_pull_low(scl_pull_low),
    .filter_coefficient(filter_coefficient), .filter_bypass(filter_bypass),
    .hv_pump_disable(hv_pump_disable), .shutdown_pin_o(shutdown_pin_o),
    .shutdown_pin_oe(shutdown_pin_oe), .alert_output_pin_o(alert_output_pin_o),
    .alert_output_pin_oe(alert_output_pin_oe),
    .acquisition_watchdog_disable(acquisition_watchdog_disable),
    .balance_watchdog_disable(balance_watchdog_disable), .aux_pin_o(aux_pin_o),
    .aux_pin_oe(aux_pin_oe), .aux_analog_sel(aux_analog_sel),
    .aux_pulldown_en(aux_pulldown_en), .sda_in(sda_in)
  );

  always #2 hclk = ~hclk;

  task automatic close_out;
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  function automatic void note(int s, logic [31:0] v);
    q.push_back('{s, v});
  endfunction : note

  // Output levels are only meaningful where the pin is driven, so aux_pin_o is masked by aux_pin_oe
  function automatic logic [31:0] obs(int s);
    case (s)
      0: obs = hrdata;
      1: obs = {23'h0, filter_coefficient, filter_bypass, hv_pump_disable, shutdown_pin_o,
                shutdown_pin_oe, acquisition_watchdog_disable, balance_watchdog_disable};
      2: obs = {7'h0, sda_in, aux_pin_o & aux_pin_oe, aux_pin_oe, aux_analog_sel,
                aux_pulldown_en};
      default: obs = {30'h0, alert_output_pin_o, alert_output_pin_oe};
    endcase
  endfunction : obs

  function automatic logic [31:0] cfg_exp(logic [15:0] r);
    cfg_exp = {23'h0, r[15:13], r[15:13] == 3'h7, r[6], 1'h0, r[5], r[1], r[0]};
  endfunction : cfg_exp

  function automatic logic [31:0] aux_exp(logic [15:0] r, logic [5:0] drv, logic sda,
                                          logic scl, logic pin0);
    logic [5:0] oe;
    logic [5:0] o;
    logic [5:0] an;
    logic [5:0] pd;
    oe = r[13:8] & r[5:0];
    o = drv & oe;
    an = ~r[13:8];
    pd = r[13:8] & ~r[5:0];
    if (r[15]) begin
      oe[1:0] = {scl, sda};
      o[1:0] = 2'h0;
      an[1:0] = 2'h0;
      pd[1:0] = 2'h0;
    end
    aux_exp = {7'h0, pin0, o, oe, an, pd};
  endfunction : aux_exp

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'h1 && k < 20);
    if (hreadyout !== 1'h1 || hresp !== 1'h0) begin
      err_total++;
      $display("mismatch at %0t: bus not ready or error response", $time);
      close_out;
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= dcr_pkg::HSIZE_WORD;
    wait_ready;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= v;
    wait_ready;
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    note(0, e);
    bus(1'h0, a, $urandom());
  endtask : rd

  task automatic probe(input int s, input logic [31:0] v);
    repeat (3) @(posedge hclk);
    note(s, v);
    look <= 1'h1;
    @(posedge hclk);
    look <= 1'h0;
  endtask : probe

  always @(posedge hclk) begin
    if (rd_dp || look) begin
      if (q.size() == 0) begin
        err_total++;
        $display("mismatch at %0t: result with no expectation", $time);
      end else begin
        n = q.pop_front();
        `CHK(obs(n.src), n.val)
      end
    end
    rd_dp = hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    seed_v = $urandom(32'h29F3FEDC);
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd({22'h0, dcr_pkg::ADDR_CFG2}, 32'h4000);
    rd({22'h0, dcr_pkg::ADDR_AUX}, 32'h3F00);
    probe(1, cfg_exp(dcr_pkg::CFG2_RESET));
    probe(2, aux_exp(dcr_pkg::AUX_RESET, 6'h0, 1'h0, 1'h0, 1'h0));
    for (int c = 0; c < 8; c++) begin
      d = $urandom();
      d[15:13] = c[2:0];
      // Forced reset stays off while the bus is busy
      d[dcr_pkg::FRST_BIT] = 1'h0;
      bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, d);
      rd({22'h0, dcr_pkg::ADDR_CFG2}, {16'h0, d[15:0] & dcr_pkg::CFG2_MASK});
      probe(1, cfg_exp(d[15:0]));
    end
    bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, 32'h0020);
    probe(1, cfg_exp(16'h0020));
    bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, 32'h0000);
    probe(1, cfg_exp(16'h0000));
    // Unmapped word just below the first register must neither store nor alias
    bus(1'h1, 32'h50, 32'hFFFF);
    rd(32'h50, 32'h0);
    rd({22'h0, dcr_pkg::ADDR_CFG2}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = $urandom();
      d[15] = i[0];
      gpio_drive <= 6'($urandom());
      aux_pin_i <= 6'($urandom());
      sda_pull_low <= 1'($urandom()) | i[1];
      scl_pull_low <= 1'($urandom());
      bus(1'h1, {22'h0, dcr_pkg::ADDR_AUX}, d);
      rd({22'h0, dcr_pkg::ADDR_AUX}, {16'h0, d[15:0] & dcr_pkg::AUX_MASK});
      probe(2, aux_exp(d[15:0], gpio_drive, sda_pull_low, scl_pull_low,
                       aux_pin_i[0]));
    end
    bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, 32'h0010);
    for (int a = 0; a < 2; a++) begin
      alert_present <= a[0];
      normal_alert_o <= 1'($urandom());
      normal_alert_oe <= 1'($urandom());
      probe(3, {30'h0, ~a[0], 1'h1});
    end
    for (int u = 0; u < 2; u++) begin
      user_alert_level <= u[0];
      user_alert_write <= 1'h1;
      @(posedge hclk);
      user_alert_write <= 1'h0;
      probe(3, {30'h0, ~u[0], 1'h1});
    end
    // Normal drive differs from the test-mode level, so a stuck test mode shows
    normal_alert_o <= 1'h1;
    normal_alert_oe <= 1'h0;
    bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, 32'h0000);
    probe(3, 32'h2);
    alert_present <= 1'h0;
    bus(1'h1, {22'h0, dcr_pkg::ADDR_CFG2}, 32'h0010);
    probe(3, 32'h3);
    repeat (4) @(posedge hclk);
    `CHK(q.size(), 0)
    close_out;
  end
endmodule : dcr_regs_tb
